// ### src/scc_conv_ctrl.v
// sequencer for a 16-bit charge-redistribution sar converter
// assumes comparator and range flags come from the analog core, asynchronous to ref_clk
`timescale 1ns/1ps
`include "scc_map.vh"
// How it works
// RULE_01 - host pulls convert_start_n low; a falling edge starts a conversion
// RULE_02 - acquiring: common node grounded, all array switches on the input
// RULE_03 - on start open both ground switches, then move the array from the input to reference ground
// RULE_04 - sixteen trial bits, msb first, weights halving down to one 65536th
// RULE_05 - after the last decision the code is formed, then busy drops
// RULE_06 - reported code belongs to the conversion just finished, no latency
// RULE_07 - coding_select high gives straight binary, low two's complement (msb flipped)
// RULE_08 - overrange saturates to ffff binary or 7fff two's complement
// RULE_09 - underrange saturates to 0000 binary or 8000 two's complement
// RULE_10 - a running conversion ignores new starts and power down
// RULE_11 - start still low at busy fall: self-timed acquisition, then auto restart
// RULE_12 - after each conversion drop to low-power acquisition, interface stays alive
// RULE_13 - busy high from start through the whole decision sequence
// RULE_14 - an internal step enable paces one bit decision per step
module scc_conv_ctrl (
    ref_clk,
    rst,
    convert_start_n,
    coding_select,
    power_down_in,
    comparator_in,
    over_range_in,
    under_range_in,
    busy,
    result,
    trial_code,
    array_ground_switch,
    dummy_ground_switch,
    array_to_input,
    array_to_ref_ground,
    low_power,
    powered_down
);
    input  wire        ref_clk;
    input  wire        rst;
    input  wire        convert_start_n;
    input  wire        coding_select;
    input  wire        power_down_in;
    input  wire        comparator_in;
    input  wire        over_range_in;
    input  wire        under_range_in;
    output reg         busy;
    output reg  [15:0] result;
    output reg  [15:0] trial_code;
    output reg         array_ground_switch;
    output reg         dummy_ground_switch;
    output reg         array_to_input;
    output reg         array_to_ref_ground;
    output reg         low_power;
    output reg         powered_down;

    localparam ST_ACQ    = 3'd0;
    localparam ST_OPEN   = 3'd1;
    localparam ST_SETTLE = 3'd2;
    localparam ST_BITS   = 3'd3;
    localparam ST_FORM   = 3'd4;
    localparam ST_AUTO   = 3'd5;

    localparam integer SETTLE_INT = `SCC_SETTLE_CYC;
    localparam integer ACQ_INT    = `SCC_ACQ_CYC;
    localparam [7:0]   SETTLE_CYC = SETTLE_INT[7:0];
    localparam [7:0]   ACQ_CYC    = ACQ_INT[7:0];

    // two-flop synchronisers; only the second stage is read
    reg [1:0] start_s_q;
    reg [1:0] cmp_s_q;
    reg [1:0] ovr_s_q;
    reg [1:0] und_s_q;
    reg [1:0] pd_s_q;
    reg [1:0] sel_s_q;
    reg       start_prev_q;

    always @(posedge ref_clk) begin
        if (rst) begin
            start_s_q    <= 2'b11;
            cmp_s_q      <= 2'b00;
            ovr_s_q      <= 2'b00;
            und_s_q      <= 2'b00;
            pd_s_q       <= 2'b00;
            sel_s_q      <= 2'b00;
            start_prev_q <= 1'b1;
        end else begin
            start_s_q    <= {start_s_q[0], convert_start_n};
            cmp_s_q      <= {cmp_s_q[0], comparator_in};
            ovr_s_q      <= {ovr_s_q[0], over_range_in};
            und_s_q      <= {und_s_q[0], under_range_in};
            pd_s_q       <= {pd_s_q[0], power_down_in};
            sel_s_q      <= {sel_s_q[0], coding_select};
            start_prev_q <= start_s_q[1];
        end
    end

    wire start_low  = ~start_s_q[1];
    wire start_fall = start_prev_q & ~start_s_q[1]; // see RULE_01

    wire step_en;
    reg  run_steps;

    scc_step_clock u_step (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (run_steps),
        .step_en (step_en)
    );

    reg [2:0]  state_q;
    reg [7:0]  cnt_q;
    reg [4:0]  bit_q;
    reg [15:0] code_q;

    always @* begin
        run_steps = (state_q == ST_BITS);
    end

    // straight binary code to the selected output coding
    function [15:0] fmt;
        input [15:0] bin;
        input        sel_bin;
        begin
            fmt = sel_bin ? bin : (bin ^ `SCC_SIGN_FLIP); // see RULE_07
        end
    endfunction

    always @(posedge ref_clk) begin
        if (rst) begin
            state_q             <= ST_ACQ;
            cnt_q               <= 8'h00;
            bit_q               <= 5'd0;
            code_q              <= 16'h0000;
            busy                <= 1'b0;
            result              <= 16'h0000;
            trial_code          <= 16'h0000;
            array_ground_switch <= 1'b1;
            dummy_ground_switch <= 1'b1;
            array_to_input      <= 1'b1;
            array_to_ref_ground <= 1'b0;
            low_power           <= 1'b1;
            powered_down        <= 1'b0;
        end else begin
            case (state_q)
            ST_ACQ: begin
                // power down only takes effect between conversions
                powered_down <= pd_s_q[1]; // see RULE_10
                if (start_fall && !pd_s_q[1]) begin
                    busy                <= 1'b1; // see RULE_13
                    low_power           <= 1'b0;
                    array_ground_switch <= 1'b0; // see RULE_03
                    dummy_ground_switch <= 1'b0;
                    state_q             <= ST_OPEN;
                end
            end
            ST_OPEN: begin
                array_to_input      <= 1'b0; // see RULE_03
                array_to_ref_ground <= 1'b1;
                cnt_q               <= 8'h00;
                state_q             <= ST_SETTLE;
            end
            ST_SETTLE: begin
                if (cnt_q == SETTLE_CYC - 8'h01) begin
                    bit_q      <= 5'd`SCC_MSB;
                    code_q     <= 16'h0000;
                    trial_code <= `SCC_MIDSCALE; // see RULE_04
                    state_q    <= ST_BITS;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            ST_BITS: begin
                if (step_en) begin
                    // comparator high keeps the trial bit
                    code_q[bit_q[3:0]] <= cmp_s_q[1]; // see RULE_04
                    if (bit_q == 5'd0) begin
                        state_q <= ST_FORM;
                    end else begin
                        trial_code <= (code_q | ({15'h0000, cmp_s_q[1]} << bit_q[3:0]))
                                      | (16'h0001 << (bit_q[3:0] - 4'h1));
                        bit_q <= bit_q - 5'd1;
                    end
                end
            end
            ST_FORM: begin
                // range flags override the search result
                if (ovr_s_q[1])
                    result <= fmt(`SCC_CODE_MAX, sel_s_q[1]); // see RULE_08
                else if (und_s_q[1])
                    result <= fmt(`SCC_CODE_MIN, sel_s_q[1]); // see RULE_09
                else
                    result <= fmt(code_q, sel_s_q[1]); // see RULE_06
                busy                <= 1'b0; // see RULE_05
                low_power           <= 1'b1; // see RULE_12
                array_ground_switch <= 1'b1; // see RULE_02
                dummy_ground_switch <= 1'b1;
                array_to_input      <= 1'b1;
                array_to_ref_ground <= 1'b0;
                cnt_q               <= 8'h00;
                state_q             <= start_low ? ST_AUTO : ST_ACQ; // see RULE_11
            end
            ST_AUTO: begin
                // self-timed acquisition; releasing start returns to idle
                if (!start_low) begin
                    state_q <= ST_ACQ;
                end else if (cnt_q == ACQ_CYC - 8'h01) begin
                    busy                <= 1'b1; // see RULE_11
                    low_power           <= 1'b0;
                    array_ground_switch <= 1'b0;
                    dummy_ground_switch <= 1'b0;
                    state_q             <= ST_OPEN;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            default: state_q <= ST_ACQ;
            endcase
        end
    end
endmodule // scc_conv_ctrl

// ### src/scc_map.vh
// constants for the sar conversion control block
// assumes a 10 mhz ref_clk; included by the control and step modules
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
`define SCC_BITS          16
`define SCC_MSB           15
`define SCC_MIDSCALE      16'h8000
`define SCC_CODE_MAX      16'hffff
`define SCC_CODE_MIN      16'h0000
`define SCC_SIGN_FLIP     16'h8000
`define SCC_CLK_MHZ       10
// three cycles a step: the comparator answer crosses two sync flops after each trial
`define SCC_STEP_DIV      3
`define SCC_SETTLE_NS     200
`define SCC_SETTLE_CYC    ((`SCC_SETTLE_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_ACQ_NS        500
`define SCC_ACQ_CYC       ((`SCC_ACQ_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_CNT_W         8
`endif

// ### src/scc_step_clock.v
// internal conversion clock: a one-cycle enable pulse every few ref_clk cycles
// assumes a single ref_clk domain and a synchronous active-high reset
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_step_clock (
    ref_clk,
    rst,
    run,
    step_en
);
    input  wire ref_clk;
    input  wire rst;
    input  wire run;
    output reg  step_en;

    reg [3:0] div_q;

    // divider restarts with each conversion so the first step is a fixed time after start
    always @(posedge ref_clk) begin
        if (rst || !run) begin
            div_q   <= 4'h0;
            step_en <= 1'b0;
        end else if (div_q == `SCC_STEP_DIV - 1) begin
            div_q   <= 4'h0;
            step_en <= 1'b1; // see RULE_14
        end else begin
            div_q   <= div_q + 4'h1;
            step_en <= 1'b0;
        end
    end
endmodule // scc_step_clock

// ### tb/scc_host_model.sv
// host side: drives the start line and plays the analog comparator
// assumes req moves just after a ref_clk edge
`timescale 1ns/1ps
module scc_host_model (
    input  logic        ref_clk,
    input  logic        req,
    input  logic [15:0] target,
    input  logic [15:0] trial_code,
    output logic        convert_start_n,
    output logic        comparator_in
);
    initial convert_start_n = 1'b1;
    // held low as long as req stays up, so a long req means auto restarts
    always @(posedge ref_clk) convert_start_n <= #1 !req;
    // ideal input: keep the trial bit while the trial word does not exceed it
    assign comparator_in = (trial_code <= target);
endmodule // scc_host_model

// ### tb/scc_conv_properties.sv
// assertions on the sequencer ports
// assumes one ref_clk domain and a synchronous active-high rst
`timescale 1ns/1ps
module scc_conv_checker (
    input logic        ref_clk,
    input logic        rst,
    input logic        convert_start_n,
    input logic        power_down_in,
    input logic        busy,
    input logic [15:0] result,
    input logic [15:0] trial_code,
    input logic        array_ground_switch,
    input logic        dummy_ground_switch,
    input logic        array_to_input,
    input logic        array_to_ref_ground,
    input logic        low_power,
    input logic        powered_down
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_open_first: assert property ($rose(busy) |->
        !array_ground_switch && !dummy_ground_switch)
        else $error("ground switches not opened at start");
    chk_ref_ground: assert property ($rose(busy) |=>
        array_to_ref_ground && !array_to_input)
        else $error("array not on reference ground");
    chk_idle_acquire: assert property (!busy |-> array_to_input
        && array_ground_switch && dummy_ground_switch && low_power && !array_to_ref_ground)
        else $error("idle state not acquiring");
    // 53 busy cycles: open, two settle, sixteen steps over 49 cycles (the first takes four), form
    chk_busy_span: assert property ($rose(busy) |->
        busy[*8] ##45 busy ##1 !busy)
        else $error("busy span wrong");
    chk_msb_trial: assert property ($rose(busy) |->
        ##[1:4] trial_code == 16'h8000)
        else $error("msb not tried first");
    chk_result_end: assert property ($changed(result) |->
        $fell(busy))
        else $error("result changed away from busy fall");
    chk_pd_ignored: assert property (busy |-> !powered_down)
        else $error("power down during conversion");
    chk_auto_start: assert property ($fell(busy) && !convert_start_n
        && !power_down_in |-> ##[3:12] $rose(busy))
        else $error("no auto restart");
    chk_no_restart: assert property ($fell(busy) && convert_start_n
        |-> !busy[*3])
        else $error("restart without request");
endmodule // scc_conv_checker

bind scc_conv_ctrl scc_conv_checker chk (.ref_clk(ref_clk), .rst(rst),
    .convert_start_n(convert_start_n), .power_down_in(power_down_in), .busy(busy),
    .result(result), .trial_code(trial_code), .array_ground_switch(array_ground_switch),
    .dummy_ground_switch(dummy_ground_switch), .array_to_input(array_to_input),
    .array_to_ref_ground(array_to_ref_ground), .low_power(low_power),
    .powered_down(powered_down));

// ### tb/scc_conv_ctrl_bench.sv
// self-checking bench for the sar sequencer
// assumes the host model plays start line and comparator
`timescale 1ns/1ps
module scc_conv_ctrl_bench;
    logic        ref_clk = 0, rst = 1, req = 0, cs = 1, pd = 0, ovr = 0, und = 0;
    logic [15:0] tgt = 0;
    wire         start_n, cmp, busy;
    wire  [15:0] result, trial;
    int          mismatches = 0, num_checks = 0;
    always #50 ref_clk = ~ref_clk;
    scc_host_model host (.ref_clk(ref_clk), .req(req), .target(tgt), .trial_code(trial),
        .convert_start_n(start_n), .comparator_in(cmp));
    scc_conv_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .convert_start_n(start_n),
        .coding_select(cs), .power_down_in(pd), .comparator_in(cmp), .over_range_in(ovr),
        .under_range_in(und), .busy(busy), .result(result), .trial_code(trial),
        .array_ground_switch(), .dummy_ground_switch(), .array_to_input(),
        .array_to_ref_ground(), .low_power(), .powered_down());
    task check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // bounded wait, a hang shows as a mismatch
    task wait_busy(input logic lvl);
        for (int i = 0; i < 80 && busy !== lvl; i++) step(1);
        check({15'h0, busy}, {15'h0, lvl});
    endtask
    task convert(input logic [15:0] t, input logic sel);
        tgt = t;
        cs = sel;
        req = 1;
        wait_busy(1);
        req = 0;
        wait_busy(0);
    endtask
    task t_codes;
        logic [15:0] v[4] = '{16'h8000, 16'h8001, 16'h0001, 16'hfffe};
        for (int i = 0; i < 8; i++) begin
            convert(v[i/2], i[0]);
            check(result, v[i/2] ^ (i[0] ? 16'h0000 : 16'h8000));
        end
        $display("codes done");
    endtask
    task t_sat;
        for (int i = 0; i < 4; i++) begin
            ovr = !i[1];
            und = i[1];
            convert(16'h1234, i[0]);
            check(result, i[1] ? {~i[0], 15'h0000} : {i[0], 15'h7fff});
        end
        ovr = 0;
        und = 0;
        $display("saturation done");
    endtask
    // second start and power down mid-run must not disturb the conversion
    task t_ignore;
        tgt = 16'h4321;
        req = 1;
        wait_busy(1);
        req = 0;
        step(10);
        req = 1;
        pd = 1;
        step(3);
        req = 0;
        wait_busy(0);
        check(result, 16'h4321);
        // power down still high: an idle start request must be refused too
        req = 1;
        step(3);
        req = 0;
        step(12);
        check({15'h0, busy}, 16'h0000);
        pd = 0;
        step(3);
        $display("ignore done");
    endtask
    task t_auto;
        tgt = 16'h00ff;
        req = 1;
        wait_busy(1);
        wait_busy(0);
        check(result, 16'h00ff);
        tgt = 16'h0f0f;
        wait_busy(1);
        req = 0;
        wait_busy(0);
        check(result, 16'h0f0f);
        step(12);
        check({15'h0, busy}, 16'h0000);
        $display("auto done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        final_report;
    end
    initial begin
        step(10);
        rst = 0;
        step(5);
        t_codes;
        t_sat;
        t_ignore;
        t_auto;
        final_report;
    end
endmodule // scc_conv_ctrl_bench
